//--- swrs_delay.sv
// Startup delay timer: busy from reset or restart until the loaded count runs out.
// Assumes the owner keeps the core in reset while busy is high.
`timescale 1ns/1ps
module swrs_delay #(
   parameter int POR_LEN = swrs_pkg::DRT_POR_CYC
) (
   input wire logic clk_i, // Clock.
   input wire logic rst_i, // Synchronous reset, loads the power-up length.
   input wire logic start_i, // Restart with len_i.
   input wire logic [swrs_pkg::CNT_W-1:0] len_i, // Length in cycles.
   output logic busy_o // High while counting.
);
   import swrs_pkg::*;

   logic [CNT_W-1:0] cnt_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= CNT_W'(POR_LEN);
         busy_o <= 1'b1;
      end else if (start_i) begin
         cnt_q <= len_i;
         busy_o <= 1'b1;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
         busy_o <= (cnt_q != CNT_W'(1));
      end else begin
         busy_o <= 1'b0;
      end
   end
endmodule

//--- swrs_pins.sv
// Model of the parts outside the unit: the master-clear pin and the three port input pins.
// Assumes the bench commands pin levels; the master-clear line has a pull-up to high.
`timescale 1ns/1ps
module swrs_pins (
   input wire logic clk_i, // Clock.
   input wire logic press_i, // Hold the master-clear button down.
   input wire logic [2:0] pins_set_i, // Levels wanted on pins 3, 1, 0.
   input wire logic dev_oe_i, // Unit drives the master-clear pin low.
   output logic master_clear_n_o, // Resolved master-clear line.
   output logic [2:0] port_pins_o // Port input pins.
);
   logic press_q;
   // Pins change only after a clock edge, like any real source synchronised to the board.
   always_ff @(posedge clk_i) begin
      press_q <= press_i;
      port_pins_o <= pins_set_i;
   end
   // The pull-up wins unless someone pulls the line low; a watchdog reset must never do so.
   assign master_clear_n_o = !(press_q || dev_oe_i);
endmodule

//--- swrs_pkg.sv
// Constants, types and the register map of the sleep, wake and reset-cause unit.
// Assumes a single 125 MHz clock that keeps running while the core sleeps.
package swrs_pkg;
   localparam int CLK_MHZ = 125;
   localparam int WDT_US = 18000;
   localparam int DRT_POR_US = 18000;
   localparam int DRT_US = 300;
   localparam int WDT_CYC = WDT_US * CLK_MHZ;
   localparam int DRT_POR_CYC = DRT_POR_US * CLK_MHZ;
   localparam int DRT_CYC = DRT_US * CLK_MHZ;
   localparam int CNT_W = 22;

   localparam logic [4:0] A_CTRL = 5'h00;
   localparam logic [4:0] A_STAT = 5'h04;
   localparam logic [4:0] A_SNAP = 5'h08;
   localparam logic [4:0] A_IRQ_ST = 5'h0c;
   localparam logic [4:0] A_IRQ_EN = 5'h10;
   localparam logic [4:0] A_IRQ_CLR = 5'h14;

   localparam int CB_WDT = 0;
   localparam int CB_WAKE = 1;
   localparam int CB_MASTER_CLEAR_N = 2;
   localparam logic [2:0] CTRL_RST = 3'h0;

   localparam int SB_SLEEP = 0;
   localparam int SB_RESET = 1;
   localparam int SB_PD = 3;
   localparam int SB_TO = 4;
   localparam int SB_PW = 7;

   localparam int IB_SLEEP = 0;
   localparam int IB_WAKE = 1;
   localparam int IB_WDT = 2;

   localparam logic [2:0] PIN_MASK_ALL = 3'h7;
   localparam logic [2:0] PIN_MASK_MASTER_CLEAR_N = 3'h3;

   typedef struct packed {
      logic pin_wake_flag;
      logic timeout_flag_n;
      logic powerdown_flag_n;
   } swrs_flags_t;

   localparam swrs_flags_t FLAGS_POR = 3'h3;

   typedef enum logic [2:0] {
      SWRS_RUN = 3'h1,
      SWRS_SLEEP = 3'h2,
      SWRS_RESET = 3'h4
   } swrs_state_t;
endpackage

//--- swrs_top.sv
// Sleep, wake-up and reset-cause sequencer with a Wishbone register slave.
// Assumes the clock runs through sleep; osc_en_o gates the core oscillator outside.
//
// The implementer's own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
module swrs_top #(
   parameter int WDT_LEN = swrs_pkg::WDT_CYC,
   parameter int DRT_POR_LEN = swrs_pkg::DRT_POR_CYC,
   parameter int DRT_LEN = swrs_pkg::DRT_CYC
) (
   input wire logic clk_i, // Clock, 125 MHz.
   input wire logic rst_i, // Power-up reset, active high.
   input wire logic wb_cyc_i, // Wishbone cycle.
   input wire logic wb_stb_i, // Wishbone strobe.
   input wire logic wb_we_i, // Wishbone write.
   input wire logic [4:0] wb_adr_i, // Byte address.
   input wire logic [3:0] wb_sel_i, // Byte lanes.
   input wire logic [31:0] wb_dat_i, // Write data.
   output logic [31:0] wb_dat_o, // Read data.
   output logic wb_ack_o, // Acknowledge.
   input wire logic sleep_exec_i, // Core executes sleep, pulse.
   input wire logic wdt_clear_i, // Core clears the watchdog, pulse.
   input wire logic port_access_i, // File or bit operation on the port, pulse.
   input wire logic [2:0] port_pins_i, // Pins 3, 1, 0 as bits 2, 1, 0.
   input wire logic master_clear_n_i, // Master-clear pin level.
   output logic core_reset_o, // Holds the core in reset.
   output logic osc_en_o, // Oscillator driver enable.
   output logic io_hold_o, // Port pins keep their state.
   output logic master_clear_oe_o, // Master-clear pin drive enable.
   output swrs_pkg::swrs_flags_t flags_o, // Reset-cause flags.
   output logic irq_o // Interrupt, level.
);
   import swrs_pkg::*;

   swrs_state_t st_q;
   swrs_state_t st_d;
   swrs_flags_t flags_d;
   logic [2:0] ctrl_q;
   logic [2:0] snap_q;
   logic [2:0] irq_st_q;
   logic [2:0] irq_en_q;
   logic por_q;
   logic in_run;
   logic in_sleep;
   logic in_reset;
   logic master_clear_n_low;
   logic pin_chg;
   logic wdt_to;
   logic wdt_run;
   logic wdt_clr;
   logic go_sleep;
   logic wake_master_clear_n;
   logic wake_wdt;
   logic wake_pin;
   logic run_master_clear_n;
   logic run_wdt;
   logic enter_rst;
   logic dly_start;
   logic dly_busy;
   logic leave_rst;
   logic [CNT_W-1:0] dly_len;
   logic [2:0] irq_ev;
   logic bus_req;
   logic bus_wr;

   assign in_run = (st_q == SWRS_RUN);
   assign in_sleep = (st_q == SWRS_SLEEP);
   assign in_reset = (st_q == SWRS_RESET);
   assign master_clear_n_low = ctrl_q[CB_MASTER_CLEAR_N] & ~master_clear_n_i;

   // With master clear enabled, pin 3 is the reset input and takes no part in the compare.
   assign pin_chg = ctrl_q[CB_WAKE] &
      (|((port_pins_i ^ snap_q) & (ctrl_q[CB_MASTER_CLEAR_N] ? PIN_MASK_MASTER_CLEAR_N : PIN_MASK_ALL)));

   // A reset cause wins over a sleep instruction in the same cycle.
   assign go_sleep = in_run & sleep_exec_i & ~master_clear_n_low & ~wdt_to;
   assign run_master_clear_n = in_run & master_clear_n_low;
   assign run_wdt = in_run & wdt_to & ~master_clear_n_low;
   assign wake_master_clear_n = in_sleep & master_clear_n_low;
   assign wake_wdt = in_sleep & wdt_to & ~master_clear_n_low;
   // A change left over from before sleep wakes on the first sleeping cycle.
   assign wake_pin = in_sleep & pin_chg & ~master_clear_n_low & ~wdt_to;
   assign enter_rst = run_master_clear_n | run_wdt | wake_master_clear_n | wake_wdt | wake_pin;

   // The watchdog only counts when software enabled it; reset and wake clear it.
   assign wdt_run = ctrl_q[CB_WDT] & (in_run | in_sleep);
   assign wdt_clr = go_sleep | enter_rst | (in_run & wdt_clear_i);

   swrs_wdt #(
      .PERIOD(WDT_LEN)
   ) u_wdt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(wdt_run),
      .clear_i(wdt_clr),
      .timeout_o(wdt_to)
   );

   // Master clear held low keeps restarting the delay, so it counts from the release.
   assign dly_start = enter_rst | (in_reset & master_clear_n_low);
   assign dly_len = por_q ? CNT_W'(DRT_POR_LEN) : CNT_W'(DRT_LEN);

   swrs_delay #(
      .POR_LEN(DRT_POR_LEN)
   ) u_delay (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(dly_start),
      .len_i(dly_len),
      .busy_o(dly_busy)
   );

   assign leave_rst = in_reset & ~dly_busy & ~dly_start;

   always_comb begin
      st_d = st_q;
      case (st_q)
         SWRS_RUN: begin
            if (enter_rst) begin
               st_d = SWRS_RESET;
            end else if (go_sleep) begin
               st_d = SWRS_SLEEP;
            end
         end
         SWRS_SLEEP: begin
            if (enter_rst) begin
               st_d = SWRS_RESET;
            end
         end
         SWRS_RESET: begin
            if (leave_rst) begin
               st_d = SWRS_RUN;
            end
         end
         default: begin
            st_d = SWRS_RESET;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= SWRS_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         por_q <= 1'b1;
      end else if (leave_rst) begin
         por_q <= 1'b0;
      end
   end

   // Flags change only on these events and are written on the edge that enters sleep or reset.
   always_comb begin
      flags_d = flags_o;
      if (go_sleep) begin
         flags_d.timeout_flag_n = 1'b1;
         flags_d.powerdown_flag_n = 1'b0;
      end else if (wake_master_clear_n) begin
         flags_d = 3'h2;
      end else if (wake_wdt) begin
         flags_d = 3'h0;
      end else if (wake_pin) begin
         flags_d = 3'h6;
      end else if (run_wdt) begin
         flags_d.timeout_flag_n = 1'b0;
         flags_d.pin_wake_flag = 1'b0;
      end else if (run_master_clear_n) begin
         flags_d.pin_wake_flag = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags_o <= FLAGS_POR;
      end else begin
         flags_o <= flags_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         snap_q <= 3'h0;
      end else if (port_access_i && in_run) begin
         snap_q <= port_pins_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         core_reset_o <= 1'b1;
         osc_en_o <= 1'b1;
         io_hold_o <= 1'b0;
         master_clear_oe_o <= 1'b0;
      end else begin
         core_reset_o <= (st_d == SWRS_RESET);
         osc_en_o <= (st_d != SWRS_SLEEP);
         io_hold_o <= (st_d == SWRS_SLEEP);
         // A watchdog reset stays inside; the pin is an input only.
         master_clear_oe_o <= 1'b0;
      end
   end

   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= CTRL_RST;
         irq_en_q <= 3'h0;
      end else if (bus_wr && wb_adr_i == A_CTRL) begin
         ctrl_q <= wb_dat_i[2:0];
      end else if (bus_wr && wb_adr_i == A_IRQ_EN) begin
         irq_en_q <= wb_dat_i[2:0];
      end
   end

   assign irq_ev[IB_SLEEP] = go_sleep;
   assign irq_ev[IB_WAKE] = wake_master_clear_n | wake_wdt | wake_pin;
   assign irq_ev[IB_WDT] = wdt_to;

   // A new event wins over a clear written in the same cycle.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_st_q <= 3'h0;
      end else if (bus_wr && wb_adr_i == A_IRQ_CLR) begin
         irq_st_q <= (irq_st_q & ~wb_dat_i[2:0]) | irq_ev;
      end else begin
         irq_st_q <= irq_st_q | irq_ev;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_st_q & irq_en_q);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= 32'h0;
         if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
               A_CTRL: wb_dat_o[2:0] <= ctrl_q;
               A_STAT: begin
                  wb_dat_o[SB_SLEEP] <= in_sleep;
                  wb_dat_o[SB_RESET] <= in_reset;
                  wb_dat_o[SB_PD] <= flags_o.powerdown_flag_n;
                  wb_dat_o[SB_TO] <= flags_o.timeout_flag_n;
                  wb_dat_o[SB_PW] <= flags_o.pin_wake_flag;
               end
               A_SNAP: wb_dat_o[2:0] <= snap_q;
               A_IRQ_ST: wb_dat_o[2:0] <= irq_st_q;
               A_IRQ_EN: wb_dat_o[2:0] <= irq_en_q;
               default: wb_dat_o <= 32'h0;
            endcase
         end
      end
   end

   sleep_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
      go_sleep |=> in_sleep && io_hold_o && !core_reset_o)
      else $error("sleep not entered");
   sleep_flags_a: assert property (@(posedge clk_i) disable iff (rst_i)
      go_sleep |=> flags_o.timeout_flag_n && !flags_o.powerdown_flag_n && !osc_en_o)
      else $error("sleep entry flags wrong");
   wdt_cleared_a: assert property (@(posedge clk_i) disable iff (rst_i)
      go_sleep |=> u_wdt.watchdog_counter_q == '0)
      else $error("watchdog not cleared on sleep");
   hold_steady_a: assert property (@(posedge clk_i) disable iff (rst_i)
      in_sleep |-> io_hold_o)
      else $error("pins not held in sleep");
   por_flags_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(rst_i) |-> flags_o == FLAGS_POR)
      else $error("power-up flags wrong");
   run_wdt_a: assert property (@(posedge clk_i) disable iff (rst_i)
      run_wdt |=> !flags_o.timeout_flag_n && !flags_o.pin_wake_flag
         && flags_o.powerdown_flag_n == $past(flags_o.powerdown_flag_n) && core_reset_o)
      else $error("watchdog reset flags wrong");
   run_master_clear_n_a: assert property (@(posedge clk_i) disable iff (rst_i)
      run_master_clear_n |=> flags_o == {1'b0, $past(flags_o[1:0])})
      else $error("master clear flags wrong");
   wake_master_clear_n_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wake_master_clear_n |=> flags_o == 3'h2 && core_reset_o)
      else $error("master clear wake flags wrong");
   wake_wdt_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wake_wdt |=> flags_o == 3'h0 && core_reset_o)
      else $error("watchdog wake flags wrong");
   wake_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wake_pin |=> flags_o == 3'h6 && core_reset_o ##1 in_reset)
      else $error("pin wake flags wrong");
   flags_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !go_sleep && !enter_rst |=> $stable(flags_o))
      else $error("flags changed without cause");
   delay_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      enter_rst |=> core_reset_o [*2])
      else $error("reset released too early");
endmodule

//--- swrs_top_test.sv
// Self-checking bench for the sleep, wake and reset-cause unit.
// Assumes shortened watchdog and delay lengths; the pin model sits on the far side.
`timescale 1ns/1ps
module swrs_top_test;
   import swrs_pkg::*;
   localparam int WL = 200;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, sleep_x = 0, wclr = 0, pacc = 0, press = 0;
   logic [4:0] adr = 5'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0, rd, wb_dat_o;
   logic [2:0] pins_set = 3'h0, port_pins;
   logic wb_ack_o, master_clear_n_n, core_reset_o, osc_en_o, io_hold_o, master_clear_n_oe, irq_o;
   swrs_flags_t flags_o;
   int mismatches = 0, comparisons = 0, n;
   always #4 clk_i = ~clk_i;
   swrs_pins pins (.clk_i(clk_i), .press_i(press), .pins_set_i(pins_set), .dev_oe_i(master_clear_n_oe),
      .master_clear_n_o(master_clear_n_n), .port_pins_o(port_pins));
   swrs_top #(.WDT_LEN(WL), .DRT_POR_LEN(50), .DRT_LEN(20)) uut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleep_exec_i(sleep_x), .wdt_clear_i(wclr),
      .port_access_i(pacc), .port_pins_i(port_pins), .master_clear_n_i(master_clear_n_n),
      .core_reset_o(core_reset_o), .osc_en_o(osc_en_o), .io_hold_o(io_hold_o),
      .master_clear_oe_o(master_clear_n_oe), .flags_o(flags_o), .irq_o(irq_o));
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // The request is held until ack is sampled high; read data is taken at that same edge.
   task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_i);
      cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 50);
      rd = wb_dat_o;
      if (k >= 50) begin
         mismatches++;
         close_out();
      end
      cyc <= 0; stb <= 0; we <= 0;
   endtask
   // One-cycle pulse: 0 port access, 1 sleep instruction, 2 master-clear button.
   task automatic pulse(input int w);
      @(posedge clk_i);
      if (w == 0) pacc <= 1;
      else if (w == 1) sleep_x <= 1;
      else press <= 1;
      @(posedge clk_i);
      pacc <= 0;
      sleep_x <= 0;
      press <= 0;
   endtask
   // Counts cycles until the core is put into reset, up to a bound.
   task automatic wait_rst(input int lim);
      n = 0;
      while (core_reset_o !== 1'b1 && n < lim) begin
         @(posedge clk_i);
         n++;
      end
      #1;
   endtask
   task automatic wait_run();
      int k;
      k = 0;
      while (core_reset_o !== 1'b0 && k < 200) begin
         @(posedge clk_i);
         k++;
      end
      if (k >= 200) begin
         mismatches++;
         close_out();
      end
   endtask
   task automatic fl(input logic [2:0] e);
      check({29'h0, flags_o}, {29'h0, e});
   endtask
   task automatic t_power_up();
      wait_run();
      fl(3'h3);
      wb(0, A_STAT, 0);
      check(rd & 32'h98, 32'h18);
      wb(0, A_CTRL, 0);
      check(rd, 32'h0);
      wb(0, 5'h18, 0);
      check(rd, 32'h0);
      $display("power-up test done");
   endtask
   task automatic t_wdt_run();
      wb(1, A_CTRL, 32'h1);
      wait_rst(400);
      check(master_clear_n_oe, 1'b0);
      fl(3'h1);
      check(core_reset_o, 1'b1);
      wb(1, A_CTRL, 32'h4);
      wait_run();
      $display("watchdog run test done");
   endtask
   task automatic t_master_clear_n();
      press <= 1;
      repeat (3) @(posedge clk_i);
      press <= 0;
      wait_rst(10);
      check(core_reset_o, 1'b1);
      fl(3'h1);
      wait_run();
      wb(1, A_CTRL, 32'h0);
      pulse(2);
      repeat (4) @(posedge clk_i);
      #1;
      check(core_reset_o, 1'b0);
      fl(3'h1);
      $display("master clear run test done");
   endtask
   task automatic t_pin_wake();
      wb(1, A_IRQ_CLR, 32'h7);
      wb(1, A_IRQ_EN, 32'h0);
      wb(1, A_CTRL, 32'h2);
      pins_set <= 3'h5;
      repeat (2) @(posedge clk_i);
      pulse(0);
      pulse(1);
      #1;
      check({io_hold_o, osc_en_o, core_reset_o}, 3'h4);
      fl(3'h2);
      repeat (5) @(posedge clk_i);
      #1;
      check(io_hold_o, 1'b1);
      pins_set <= 3'h4;
      wait_rst(10);
      fl(3'h6);
      check({io_hold_o, osc_en_o}, 2'h1);
      wait_run();
      wb(0, A_IRQ_ST, 0);
      check(rd, 32'h3);
      check(irq_o, 1'b0);
      wb(1, A_IRQ_EN, 32'h2);
      wb(0, A_SNAP, 0);
      check(rd, 32'h5);
      check(irq_o, 1'b1);
      wb(1, A_IRQ_CLR, 32'h2);
      wb(0, A_IRQ_ST, 0);
      check({rd[1:0], irq_o}, 3'h2);
      $display("pin wake test done");
   endtask
   task automatic t_pending();
      wb(1, A_CTRL, 32'h2);
      // The snapshot still holds the levels from before the last wake, so these pins differ from it.
      pins_set <= 3'h4;
      repeat (2) @(posedge clk_i);
      pulse(1);
      wait_rst(3);
      check(core_reset_o, 1'b1);
      fl(3'h6);
      wait_run();
      $display("pending change test done");
   endtask
   task automatic t_master_clear_n_sleep();
      wb(1, A_CTRL, 32'h6);
      pulse(0);
      pulse(1);
      repeat (4) @(posedge clk_i);
      #1;
      check(core_reset_o, 1'b0);
      pulse(2);
      wait_rst(6);
      fl(3'h2);
      wait_run();
      $display("master clear sleep test done");
   endtask
   task automatic t_wdt_sleep();
      wb(1, A_CTRL, 32'h1);
      repeat (100) @(posedge clk_i);
      pulse(1);
      wait_rst(400);
      check(n >= WL - 4 && n <= WL + 4, 1'b1);
      fl(3'h0);
      wait_run();
      wait_rst(400);
      check(n >= WL - 25 && n <= WL + 4, 1'b1);
      wb(1, A_CTRL, 32'h0);
      wait_run();
      $display("watchdog sleep test done");
   endtask
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 0;
      t_power_up();
      t_wdt_run();
      t_master_clear_n();
      t_pin_wake();
      t_pending();
      t_master_clear_n_sleep();
      t_wdt_sleep();
      close_out();
   end
   // Every test together needs well under five thousand cycles; this bound only catches a hang.
   initial begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      close_out();
   end
endmodule

//--- swrs_wdt.sv
// Watchdog counter that runs while enabled and pulses on time-out.
// Assumes clear and run come from the owning sequencer.
`timescale 1ns/1ps
module swrs_wdt #(
   parameter int PERIOD = swrs_pkg::WDT_CYC
) (
   input wire logic clk_i, // Clock.
   input wire logic rst_i, // Synchronous reset.
   input wire logic run_i, // Count enable.
   input wire logic clear_i, // Clear the count.
   output logic timeout_o // One-cycle time-out pulse.
);
   import swrs_pkg::*;

   logic [CNT_W-1:0] watchdog_counter_q;

   always_ff @(posedge clk_i) begin
      if (rst_i || clear_i || !run_i) begin
         watchdog_counter_q <= '0;
         timeout_o <= 1'b0;
      end else if (watchdog_counter_q >= CNT_W'(PERIOD - 1)) begin
         watchdog_counter_q <= '0;
         timeout_o <= 1'b1;
      end else begin
         watchdog_counter_q <= watchdog_counter_q + 1'b1;
         timeout_o <= 1'b0;
      end
   end
endmodule
